// ===== rtl/iat_pkg.sv
/*
 * Package for the interrupt acceptance timing block: constants, the
 * CPU status carrier and the acceptance result carrier.
 * Assumes a single 40 MHz system clock.
 */
package iat_pkg;
    localparam int NUM_SRC = 8;
    localparam int SRC_IDX_W = 3;
    localparam int PC_W = 24;
    // Mask write takes effect this many states after the instruction ends
    localparam logic [1:0] MASK_DELAY_STATES = 2'h2;
    localparam logic [1:0] MASK_DELAY_LAST = 2'h1;
    localparam logic [1:0] MASK_DELAY_IDLE = 2'h0;
    localparam logic I_MASK_RESET = 1'h1;
    localparam logic UI_MASK_RESET = 1'h0;

    typedef enum logic [1:0] {
        IAT_KIND_NONE,
        IAT_KIND_NMI,
        IAT_KIND_BRK,
        IAT_KIND_SRC
    } iat_kind_t;

    // Status the CPU core reports every cycle
    typedef struct packed {
        logic insn_end;          // Pulse: current instruction completes
        logic ccr_write;         // Ending insn loads or modifies the condition code register
        logic new_i_mask;        // Value of the interrupt mask bit written
        logic new_user_mask_bit; // Value of the user mask bit written
        logic block_move_byte_insn;
        logic block_move_word_insn;
        logic transfer_break;    // Pulse: gap between block move transfer cycles
        logic [PC_W-1:0] next_pc;
    } iat_cpu_t;

    // Accepted request handed to the CPU exception sequencer
    typedef struct packed {
        logic valid;
        iat_kind_t kind;
        logic [SRC_IDX_W-1:0] src_idx;
        logic [PC_W-1:0] stacked_pc;
    } iat_accept_t;
endpackage

// ===== rtl/iat_prio_pick.sv
/*
 * Fixed priority picker: lowest index wins, binary-encoded index out.
 * Assumes the caller orders requests by priority.
 */
`timescale 1ns/1ps
`default_nettype none
module iat_prio_pick #(
    parameter int N = 8,
    parameter int W = 3
) (
    // Requests
    input wire logic [N-1:0] req,
    // Result
    output logic any,
    output logic [W-1:0] idx
);
    always_comb begin
        idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (req[k]) begin
                idx = W'(k);
            end
        end
    end
    assign any = |req;
endmodule
`default_nettype wire

// ===== rtl/iat_accept.sv
/*
 * Interrupt acceptance timing: decides at each instruction boundary, or
 * at a transfer break of a word block move, which request the CPU takes.
 * Assumes synchronous inputs; flags and enables come from the peripherals.
 */
// Operation
// (R1) Enable clear acts after clearing instruction ends
// (R2) Request during clearing instruction still gets serviced
// (R3) Higher priority wins, lower conflicting request dropped
// (R4) Source flag clear behaves the same way
// (R5) Clear while masked yields no exception
// (R6) No interrupt after condition code writing instruction
// (R7) New mask bits effective two states later
// (R8) Byte block move never interrupted mid-transfer
// (R9) Word block move interruptible at transfer breaks
// (R10) Stacked PC is the following instruction
// (R11) Software loops word move while count nonzero
// (R12) Software clears stale irq status flags after reset
// (R13) Both masks set: only NMI and break accepted
// (R14) Exception handling starts only after instruction completes; code also accepts at word block move transfer breaks
// (R15) Evaluate bits with values at the boundary
`timescale 1ns/1ps
`default_nettype none
module iat_accept #(
    parameter int NUM_SRC = iat_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Peripheral requests, index 0 highest priority
    input wire logic [NUM_SRC-1:0] src_flag,
    input wire logic [NUM_SRC-1:0] src_enable,
    input wire logic [NUM_SRC-1:0] src_level1,
    input wire logic nmi_req,
    input wire logic brk_req,
    // CPU core
    input wire iat_pkg::iat_cpu_t cpu,
    output iat_pkg::iat_accept_t accept,
    output logic i_mask_eff,
    output logic user_mask_eff
);
    logic [NUM_SRC-1:0] armed_q, armed_d;
    logic i_q, ui_q, i_pend_q, ui_pend_q;
    logic [1:0] dly_q;
    iat_pkg::iat_accept_t acc_q;

    // Per-source masking with the masks in effect now
    wire logic [NUM_SRC-1:0] src_masked;
    wire logic [NUM_SRC-1:0] src_live;
    wire logic [NUM_SRC-1:0] cand;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            assign src_masked[g] = i_q & (~src_level1[g] | ui_q); // [R13]
            assign src_live[g] = src_flag[g] & src_enable[g] & ~src_masked[g]; // [R5]
            // Seen while its instruction ran still counts at the boundary
            assign cand[g] = (armed_q[g] & ~src_masked[g]) | src_live[g]; // [R1] [R2] [R4] [R15]
        end
    endgenerate

    // Acceptance points
    wire logic word_break = cpu.block_move_word_insn & cpu.transfer_break; // [R9]
    wire logic byte_busy = cpu.block_move_byte_insn & ~cpu.insn_end; // [R8]
    wire logic boundary = (cpu.insn_end | word_break) & ~byte_busy; // [R14]
    wire logic inhibit = cpu.insn_end & cpu.ccr_write; // [R6]
    wire logic take_pt = boundary & ~inhibit;

    wire logic src_any;
    wire logic [iat_pkg::SRC_IDX_W-1:0] src_idx;
    iat_prio_pick #(.N(NUM_SRC), .W(iat_pkg::SRC_IDX_W)) u_pick (
        .req(cand),
        .any(src_any),
        .idx(src_idx)
    );

    wire logic take_any = take_pt & (nmi_req | brk_req | src_any);
    wire iat_pkg::iat_kind_t take_kind = nmi_req ? iat_pkg::IAT_KIND_NMI :
        brk_req ? iat_pkg::IAT_KIND_BRK : iat_pkg::IAT_KIND_SRC; // [R3]

    // Armed set collects requests up to the next acceptance point; cleared there
    always_comb begin
        armed_d = armed_q | src_live;
        if (take_pt) begin
            armed_d = '0; // [R3]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            armed_q <= '0;
        end else begin
            armed_q <= armed_d;
        end
    end

    // Delayed mask update
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            i_q <= iat_pkg::I_MASK_RESET;
            ui_q <= iat_pkg::UI_MASK_RESET;
            i_pend_q <= iat_pkg::I_MASK_RESET;
            ui_pend_q <= iat_pkg::UI_MASK_RESET;
            dly_q <= iat_pkg::MASK_DELAY_IDLE;
        end else if (inhibit) begin
            i_pend_q <= cpu.new_i_mask;
            ui_pend_q <= cpu.new_user_mask_bit;
            dly_q <= iat_pkg::MASK_DELAY_STATES; // [R7]
        end else if (dly_q != iat_pkg::MASK_DELAY_IDLE) begin
            dly_q <= dly_q - 2'h1;
            if (dly_q == iat_pkg::MASK_DELAY_LAST) begin
                i_q <= i_pend_q; // [R7]
                ui_q <= ui_pend_q;
            end
        end
    end

    // Acceptance result, one-cycle valid
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc_q <= '0;
        end else begin
            acc_q.valid <= take_any;
            if (take_any) begin
                acc_q.kind <= take_kind;
                acc_q.src_idx <= src_idx;
                acc_q.stacked_pc <= cpu.next_pc; // [R10]
            end
        end
    end

    assign accept = acc_q;
    assign i_mask_eff = i_q;
    assign user_mask_eff = ui_q;

    // Checks
    sequence ccr_end_s;
        cpu.insn_end && cpu.ccr_write;
    endsequence

    mask_delay_two_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ccr_end_s ##1 !(cpu.insn_end && cpu.ccr_write) [*2]
        |=> i_q == $past(cpu.new_i_mask, 3)) // [R7]
        else $error("mask not applied two states after write");
    mask_hold_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ccr_end_s ##1 !(cpu.insn_end && cpu.ccr_write) |-> i_q == $past(i_q))
        // [R7]
        else $error("mask applied too early");
    no_take_ccr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ccr_end_s |=> !accept.valid) // [R6]
        else $error("interrupt taken after condition code write");
    byte_move_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cpu.block_move_byte_insn && !cpu.insn_end |=> !accept.valid) // [R8]
        else $error("byte block move interrupted");
    word_break_take_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cpu.block_move_word_insn && cpu.transfer_break && !cpu.ccr_write && nmi_req
        |=> accept.valid && accept.kind == iat_pkg::IAT_KIND_NMI) // [R9]
        else $error("word block move break not taken");
    stacked_pc_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take_any |=> accept.stacked_pc == $past(cpu.next_pc)) // [R10]
        else $error("stacked pc not the next instruction");
    only_boundary_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept.valid |-> $past(cpu.insn_end || word_break)) // [R14]
        else $error("accepted away from a boundary");
    conflict_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        armed_q[0] && !src_masked[0] && take_pt && !nmi_req && !brk_req
        |=> accept.valid && accept.src_idx == '0) // [R2]
        else $error("armed request lost at boundary");
    both_masks_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept.valid && $past(i_q && ui_q) |-> accept.kind != iat_pkg::IAT_KIND_SRC)
        // [R13]
        else $error("maskable taken with both masks set");
    nmi_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take_pt && nmi_req |=> accept.kind == iat_pkg::IAT_KIND_NMI) // [R3]
        else $error("priority order broken");
endmodule
`default_nettype wire

// ===== verif/iat_cpu_model.sv
/* CPU core model: one instruction per run call; assumes one caller. */
`timescale 1ns/1ps
`default_nettype none
module iat_cpu_model (
    // Clock
    input wire logic clk_sys,
    // Core status
    output iat_pkg::iat_cpu_t cpu
);
    initial cpu = '0;
    task automatic run(input int n, input logic [4:0] f, input logic [23:0] pc);
        iat_pkg::iat_cpu_t c;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk_sys) #1;
            c = '0;
            if (i < n) begin
                c.insn_end = i == n - 1;
                c.ccr_write = f[4] & c.insn_end;
                {c.new_i_mask, c.new_user_mask_bit} = f[3:2];
                {c.block_move_byte_insn, c.block_move_word_insn} = f[1:0];
                c.transfer_break = |f[1:0] & ~c.insn_end;
                c.next_pc = pc;
            end
            cpu = c;
        end
    endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
/* Self-checking bench for interrupt acceptance; assumes iat_cpu_model. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0, sys_rst = 1'b1, nmi = 1'b0, brk = 1'b0, ie, ue;
    logic [7:0] flg = 8'h00, en = 8'hFF, lv = 8'h00;
    logic [23:0] pc = 24'h000100;
    iat_pkg::iat_cpu_t cpu;
    iat_pkg::iat_accept_t acc, e, q[$];
    int error_cnt = 0, total_checks = 0, seed = 56;
    always #12.5 clk_sys = ~clk_sys;
    iat_accept i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .src_flag(flg), .src_enable(en),
        .src_level1(lv), .nmi_req(nmi), .brk_req(brk), .cpu(cpu), .accept(acc),
        .i_mask_eff(ie), .user_mask_eff(ue));
    iat_cpu_model i_cpu (.clk_sys(clk_sys), .cpu(cpu));
    task automatic chk(input logic [31:0] s, x, input string m);
        total_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic step(input int n, input logic [4:0] f, input logic clr);
        fork
            i_cpu.run(n, f, pc);
            begin
                repeat (n + 1) @(posedge clk_sys) #1;
                if (clr) {flg, nmi, brk} = '0;
            end
        join
    endtask
    task automatic done(input string m);
        repeat (2) @(posedge clk_sys) #1;
        chk(q.size(), 0, m);
        $display("test %s done", m);
        pc = $random(seed);
    endtask
    always @(negedge clk_sys) begin
        if (acc.valid === 1'b1) begin
            e = q.size() > 0 ? q.pop_front() : '0;
            chk(acc.kind, e.kind, "kind");
            chk(acc.stacked_pc, e.stacked_pc, "pc");
            if (e.kind == iat_pkg::IAT_KIND_SRC) chk(acc.src_idx, e.src_idx, "idx");
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys) #1;
        sys_rst = 1'b0;
        nmi = 1'b1;
        step(2, 5'h10, 1'b0);
        chk(ie, 1'b1, "mask early");
        @(posedge clk_sys) #1;
        chk(ie, 1'b1, "mask early");
        @(posedge clk_sys) #1;
        chk(ie, 1'b0, "mask late");
        q.push_back({1'b1, iat_pkg::IAT_KIND_NMI, 3'h0, pc});
        step(1, 5'h00, 1'b1);
        done("ccr");
        for (int m = 0; m < 3; m++) begin
            flg = 8'h08;
            q.push_back({1'b1, iat_pkg::IAT_KIND_SRC, m == 2 ? 3'h1 : 3'h3, pc});
            fork
                step(4, 5'h00, 1'b1);
                begin
                    repeat (2) @(posedge clk_sys) #1;
                    if (m == 1) flg = 8'h00;
                    else en = 8'hF7;
                    if (m == 2) flg = 8'h0A;
                end
            join
            en = 8'hFF;
            done("clear");
        end
        nmi = 1'b1;
        q.push_back({1'b1, iat_pkg::IAT_KIND_NMI, 3'h0, pc});
        step(3, 5'h02, 1'b1);
        brk = 1'b1;
        repeat (3) q.push_back({1'b1, iat_pkg::IAT_KIND_BRK, 3'h0, pc});
        step(3, 5'h01, 1'b1);
        step(2, 5'h01, 1'b1);
        done("moves");
        step(1, 5'h1C, 1'b1);
        {lv, flg, brk} = {8'hFF, 8'h01, 1'b1};
        q.push_back({1'b1, iat_pkg::IAT_KIND_BRK, 3'h0, pc});
        step(2, 5'h00, 1'b1);
        step(1, 5'h00, 1'b1);
        chk(ue, 1'b1, "user mask");
        done("masked");
        stop_test();
    end
endmodule
`default_nettype wire
